// ==== rtl/diag_pkg.sv ====
// Shared constants, types and helpers of the diagnostic memory block.
package diag_pkg;
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int ACTIVITY_PERIOD_MS = 16;
  localparam int ACTIVITY_TICK_CYCLES = ACTIVITY_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int DIAG_BYTES = 64;
  localparam int ADDR_W = 6;
  localparam int ERR_CODE_W = 12;
  localparam int CSUM_BYTES = 4;

  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_ACT_LO = 6'h01;
  localparam logic [5:0] OFS_ACT_HI = 6'h02;
  localparam logic [5:0] OFS_COMP_STATE = 6'h03;
  localparam logic [5:0] OFS_RESET_CAUSE = 6'h04;
  localparam logic [5:0] OFS_RSVD_A_LO = 6'h05;
  localparam logic [5:0] OFS_RSVD_A_HI = 6'h0A;
  localparam logic [5:0] OFS_ERR_COUNT = 6'h0B;
  localparam logic [5:0] OFS_CODE_LO = 6'h0C;
  localparam logic [5:0] OFS_CODE_HI = 6'h0D;
  localparam logic [5:0] OFS_ECC_COUNT = 6'h0E;
  localparam logic [5:0] OFS_SHUTDOWN = 6'h0F;
  localparam logic [5:0] OFS_CHECKSUM = 6'h14;

  localparam logic [7:0] MODE_CLEARED = 8'h00;
  localparam logic [7:0] MODE_STANDBY = 8'h01;
  localparam logic [7:0] MODE_DISPLAY = 8'h02;
  localparam logic [7:0] SHUTDOWN_NONE = 8'h00;
  localparam logic [7:0] SHUTDOWN_SET = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [3:0] CODE_UNUSED = 4'h0;

  localparam logic [4:0] CAUSE_MIN = 5'h01;
  localparam logic [4:0] CAUSE_MAX = 5'h17;
  localparam logic [4:0] CAUSE_UNUSED = 5'h0F;

  typedef logic [DIAG_BYTES-1:0][7:0] diag_image_t;

  typedef struct packed {
    logic valid;
    logic clear;
    logic [ADDR_W-1:0] addr;
  } diag_req_t;

  typedef struct packed {
    logic valid;
    logic [ERR_CODE_W-1:0] code;
    logic ecc;
  } err_event_t;

  typedef enum logic [2:0] {
    SD_RUN = 3'b001,
    SD_PARK = 3'b010,
    SD_OFF = 3'b100
  } sd_state_t;

  function automatic logic cause_valid(input logic [4:0] idx);
    return (idx >= CAUSE_MIN) && (idx <= CAUSE_MAX) && (idx != CAUSE_UNUSED);
  endfunction : cause_valid
endpackage : diag_pkg

// ==== rtl/diag_reader.sv ====
// Registered byte read port onto the diagnostic memory image.
`timescale 1ns/1ps
`default_nettype none
module diag_reader (
  input wire logic clk_sys,
  input wire logic reset,
  input wire diag_pkg::diag_req_t req,
  input wire diag_pkg::diag_image_t image,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  // Reads are answered one cycle later; clear requests get no data.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_valid <= 1'b0;
      rd_data <= diag_pkg::BYTE_ZERO;
    end
    else
    begin
      rd_valid <= req.valid && !req.clear;
      if (req.valid && !req.clear)
      begin
        rd_data <= image[req.addr];
      end
    end
  end
endmodule : diag_reader
`default_nettype wire

// ==== rtl/shutdown_ctrl.sv ====
// Emergency shutdown sequencer for illumination, mirror array and interrupt.
`timescale 1ns/1ps
`default_nettype none
module shutdown_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic trigger,
  input wire logic illum_req,
  input wire logic mirror_parked,
  output logic illum_en,
  output logic mirror_park,
  output logic mirror_power_en,
  output logic host_irq,
  output logic latched
);
  diag_pkg::sd_state_t state_q;

  // The state only leaves the off state through a full reset.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= diag_pkg::SD_RUN;
    end
    else
    begin
      unique case (state_q)
        diag_pkg::SD_RUN:
          if (trigger) state_q <= diag_pkg::SD_PARK;
        diag_pkg::SD_PARK:
          if (mirror_parked) state_q <= diag_pkg::SD_OFF;
        diag_pkg::SD_OFF:
          state_q <= diag_pkg::SD_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      illum_en <= 1'b0;
      mirror_park <= 1'b0;
      mirror_power_en <= 1'b1;
      host_irq <= 1'b0;
      latched <= 1'b0;
    end
    else if (trigger || state_q != diag_pkg::SD_RUN)
    begin
      illum_en <= 1'b0;
      mirror_park <= 1'b1;
      host_irq <= 1'b1;
      latched <= 1'b1;
      if (state_q == diag_pkg::SD_PARK && mirror_parked)
      begin
        mirror_power_en <= 1'b0;
      end
    end
    else
    begin
      illum_en <= illum_req;
    end
  end

  sequence s_parking;
    state_q == diag_pkg::SD_PARK && mirror_parked;
  endsequence

  sequence s_powered_off;
    !mirror_power_en && mirror_park && !illum_en;
  endsequence

  property p_park_power_off;
    @(posedge clk_sys) disable iff (reset)
    s_parking |=> s_powered_off ##1 s_powered_off;
  endproperty
  a_park_power_off: assert property (p_park_power_off)
    else $error("Mirror array not powered down after parking.");
endmodule : shutdown_ctrl
`default_nettype wire

// ==== rtl/diag_monitor.sv ====
// Diagnostic memory with its read and clear port and shutdown reaction.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Shutdown: lights off, mirror parked, standby.
// - Shutdown sets status flag and host interrupt.
// - Shutdown causes indexed 1 to 23, not 15.
// - Sixty-four byte memory, internally updated, host readable.
// - Diagnostic protocol opposite host port, sampled power-up.
// - Diagnostic reads and clears done in hardware.
// - Diagnostic framing same as host command port.
// - Clear request zeroes any requested byte.
// - Host command port cannot clear the memory.
// - Byte 0 holds mode, rewritten on change.
// - Bytes 2:1 activity counter, every 16 ms.
// - Byte 3 reports power companion state.
// - Byte 4 holds last reset cause.
// - Byte 11 error count copy; clear keeps count.
// - Bytes 13:12 hold latest 12-bit error code.
// - Byte 14 counts ECC errors since reset.
// - Byte 15 reads one after emergency shutdown.
// - Bytes 23:20 hold per-frame video checksum.
module diag_monitor #(
  parameter int ACTIVITY_TICK = diag_pkg::ACTIVITY_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic host_if_sel,
  input wire diag_pkg::diag_req_t diag_req,
  output logic diag_rd_valid,
  output logic [7:0] diag_rd_data,
  output logic diag_uses_spi,
  input wire logic host_rd_req,
  input wire logic [diag_pkg::ADDR_W-1:0] host_rd_addr,
  output logic host_rd_valid,
  output logic [7:0] host_rd_data,
  input wire logic sw_alive,
  input wire logic mode_req,
  input wire logic mode_req_display,
  input wire logic [7:0] comp_state,
  input wire logic [7:0] reset_cause,
  input wire diag_pkg::err_event_t err_event,
  input wire logic video_frame_done,
  input wire logic [31:0] video_checksum,
  input wire logic shutdown_req,
  input wire logic [4:0] shutdown_cause,
  input wire logic illum_req,
  input wire logic mirror_parked,
  output logic illum_en,
  output logic mirror_park,
  output logic mirror_power_en,
  output logic host_irq,
  output logic shutdown_flag,
  output logic [4:0] shutdown_cause_q,
  output logic [7:0] operating_mode
);
  localparam int TW = $clog2(ACTIVITY_TICK + 1);

  diag_pkg::diag_image_t mem_q;
  diag_pkg::diag_req_t host_req;
  logic cap_done_q;
  logic init_pulse;
  logic [TW-1:0] tick_cnt_q;
  logic tick;
  logic alive_seen_q;
  logic act_inc;
  logic [15:0] activity_q;
  logic [15:0] activity_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] comp_last_q;
  logic [7:0] err_count_q;
  logic [7:0] ecc_count_q;
  logic sd_event;
  logic diag_clear;

  assign init_pulse = !cap_done_q;
  assign tick = (tick_cnt_q == TW'(ACTIVITY_TICK - 1));
  assign act_inc = tick && alive_seen_q;
  assign activity_d = activity_q + 16'h0001;
  assign sd_event = shutdown_req && !shutdown_flag &&
                    diag_pkg::cause_valid(shutdown_cause);
  assign diag_clear = diag_req.valid && diag_req.clear;
  assign operating_mode = mode_q;
  // The host port carries no clear bit at all.
  assign host_req = '{valid: host_rd_req, clear: 1'b0, addr: host_rd_addr};

  // The strap is caught once, in the first cycle after reset release.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cap_done_q <= 1'b0;
      diag_uses_spi <= 1'b0;
    end
    else if (!cap_done_q)
    begin
      cap_done_q <= 1'b1;
      // High select puts the host on SPI, so diagnostics use I2C.
      diag_uses_spi <= !host_if_sel;
    end
  end

  // Activity tick divider; a tick only counts if software was alive.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tick_cnt_q <= '0;
      alive_seen_q <= 1'b0;
      activity_q <= 16'h0000;
    end
    else
    begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      if (tick)
      begin
        alive_seen_q <= sw_alive;
      end
      else if (sw_alive)
      begin
        alive_seen_q <= 1'b1;
      end
      if (act_inc)
      begin
        activity_q <= activity_d;
      end
    end
  end

  // Operating mode; a shutdown forces standby and blocks display.
  always_comb
  begin
    mode_d = mode_q;
    if (sd_event || shutdown_flag)
    begin
      mode_d = diag_pkg::MODE_STANDBY;
    end
    else if (mode_req)
    begin
      mode_d = mode_req_display ? diag_pkg::MODE_DISPLAY
                                : diag_pkg::MODE_STANDBY;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_q <= diag_pkg::MODE_STANDBY;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // Underlying counts that a diagnostic clear never touches.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      err_count_q <= diag_pkg::BYTE_ZERO;
      ecc_count_q <= diag_pkg::BYTE_ZERO;
      comp_last_q <= diag_pkg::BYTE_ZERO;
      shutdown_cause_q <= 5'h00;
    end
    else
    begin
      comp_last_q <= comp_state;
      if (err_event.valid)
      begin
        err_count_q <= err_count_q + diag_pkg::COUNT_STEP;
        if (err_event.ecc)
        begin
          ecc_count_q <= ecc_count_q + diag_pkg::COUNT_STEP;
        end
      end
      if (sd_event)
      begin
        shutdown_cause_q <= shutdown_cause;
      end
    end
  end

  // Memory image: a clear comes first so that a same-cycle update wins.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mem_q <= '0;
    end
    else
    begin
      if (diag_clear)
      begin
        mem_q[diag_req.addr] <= diag_pkg::BYTE_ZERO;
      end
      if (init_pulse || mode_d != mode_q)
      begin
        mem_q[diag_pkg::OFS_MODE] <= mode_d;
      end
      if (act_inc)
      begin
        mem_q[diag_pkg::OFS_ACT_LO] <= activity_d[7:0];
        mem_q[diag_pkg::OFS_ACT_HI] <= activity_d[15:8];
      end
      if (init_pulse || comp_state != comp_last_q)
      begin
        mem_q[diag_pkg::OFS_COMP_STATE] <= comp_state;
      end
      if (init_pulse)
      begin
        mem_q[diag_pkg::OFS_RESET_CAUSE] <= reset_cause;
      end
      if (err_event.valid)
      begin
        mem_q[diag_pkg::OFS_ERR_COUNT] <= err_count_q + diag_pkg::COUNT_STEP;
        mem_q[diag_pkg::OFS_CODE_LO] <= err_event.code[7:0];
        mem_q[diag_pkg::OFS_CODE_HI] <= {diag_pkg::CODE_UNUSED,
                                         err_event.code[11:8]};
        if (err_event.ecc)
        begin
          mem_q[diag_pkg::OFS_ECC_COUNT] <= ecc_count_q +
                                            diag_pkg::COUNT_STEP;
        end
      end
      if (sd_event || (shutdown_flag && err_event.valid))
      begin
        mem_q[diag_pkg::OFS_SHUTDOWN] <= diag_pkg::SHUTDOWN_SET;
      end
      if (video_frame_done)
      begin
        for (int i = 0; i < diag_pkg::CSUM_BYTES; i++)
        begin
          mem_q[diag_pkg::OFS_CHECKSUM + 6'(i)] <=
            video_checksum[8*i +: 8];
        end
      end
    end
  end

  // Both ports use their own instance of the same read engine, hence identical framing.
  diag_reader u_diag_reader (
    .clk_sys(clk_sys),
    .reset(reset),
    .req(diag_req),
    .image(mem_q),
    .rd_valid(diag_rd_valid),
    .rd_data(diag_rd_data)
  );

  diag_reader u_host_reader (
    .clk_sys(clk_sys),
    .reset(reset),
    .req(host_req),
    .image(mem_q),
    .rd_valid(host_rd_valid),
    .rd_data(host_rd_data)
  );

  shutdown_ctrl u_shutdown_ctrl (
    .clk_sys(clk_sys),
    .reset(reset),
    .trigger(sd_event),
    .illum_req(illum_req),
    .mirror_parked(mirror_parked),
    .illum_en(illum_en),
    .mirror_park(mirror_park),
    .mirror_power_en(mirror_power_en),
    .host_irq(host_irq),
    .latched(shutdown_flag)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_sd_dark;
    sd_event |=> !illum_en && mirror_park;
  endproperty
  a_sd_dark: assert property (p_sd_dark)
    else $error("Shutdown did not darken and park.");

  property p_sd_irq;
    sd_event |=> host_irq && shutdown_flag;
  endproperty
  a_sd_irq: assert property (p_sd_irq)
    else $error("Shutdown did not raise flag and interrupt.");

  property p_sd_standby;
    sd_event |=> (operating_mode == diag_pkg::MODE_STANDBY) [*8];
  endproperty
  a_sd_standby: assert property (p_sd_standby)
    else $error("Mode left standby after shutdown.");

  property p_bad_cause;
    shutdown_req && !shutdown_flag &&
    !diag_pkg::cause_valid(shutdown_cause) |=> !shutdown_flag;
  endproperty
  a_bad_cause: assert property (p_bad_cause)
    else $error("Invalid cause index caused a shutdown.");

  property p_proto_fixed;
    cap_done_q && $past(cap_done_q) |-> $stable(diag_uses_spi);
  endproperty
  a_proto_fixed: assert property (p_proto_fixed)
    else $error("Diagnostic protocol changed after power-up.");

  property p_rsvd_zero;
    diag_req.valid && !diag_req.clear &&
    diag_req.addr inside {[diag_pkg::OFS_RSVD_A_LO:diag_pkg::OFS_RSVD_A_HI]}
    |=> diag_rd_valid && diag_rd_data == diag_pkg::BYTE_ZERO;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved byte did not read zero.");

  property p_clear_ecc;
    diag_clear && diag_req.addr == diag_pkg::OFS_ECC_COUNT &&
    !err_event.valid |=> mem_q[diag_pkg::OFS_ECC_COUNT] == diag_pkg::BYTE_ZERO;
  endproperty
  a_clear_ecc: assert property (p_clear_ecc)
    else $error("Clear request left the byte nonzero.");

  property p_only_diag_clears;
    mem_q[diag_pkg::OFS_ECC_COUNT] == diag_pkg::BYTE_ZERO &&
    $past(mem_q[diag_pkg::OFS_ECC_COUNT]) != diag_pkg::BYTE_ZERO
    |-> $past(diag_clear && diag_req.addr == diag_pkg::OFS_ECC_COUNT);
  endproperty
  a_only_diag_clears: assert property (p_only_diag_clears)
    else $error("Byte cleared without a diagnostic clear.");

  property p_err_copy;
    err_event.valid |=> mem_q[diag_pkg::OFS_ERR_COUNT] == err_count_q &&
                        err_count_q == $past(err_count_q) + 8'h01;
  endproperty
  a_err_copy: assert property (p_err_copy)
    else $error("Error count copy not rewritten from the count.");

  property p_err_code;
    err_event.valid |=> {mem_q[diag_pkg::OFS_CODE_HI],
                         mem_q[diag_pkg::OFS_CODE_LO]} ==
                        {diag_pkg::CODE_UNUSED, $past(err_event.code)};
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("Last error code byte pair wrong.");

  property p_mode_byte;
    $changed(operating_mode) |-> mem_q[diag_pkg::OFS_MODE] == operating_mode;
  endproperty
  a_mode_byte: assert property (p_mode_byte)
    else $error("Mode byte not updated on mode change.");

  property p_activity;
    act_inc |=> {mem_q[diag_pkg::OFS_ACT_HI], mem_q[diag_pkg::OFS_ACT_LO]}
                == activity_q;
  endproperty
  a_activity: assert property (p_activity)
    else $error("Activity counter bytes not updated.");

  property p_checksum;
    video_frame_done |=> {mem_q[diag_pkg::OFS_CHECKSUM + 6'h03],
                          mem_q[diag_pkg::OFS_CHECKSUM + 6'h02],
                          mem_q[diag_pkg::OFS_CHECKSUM + 6'h01],
                          mem_q[diag_pkg::OFS_CHECKSUM]} ==
                         $past(video_checksum);
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("Video checksum bytes wrong.");

  property p_sd_byte;
    sd_event |=> mem_q[diag_pkg::OFS_SHUTDOWN] == diag_pkg::SHUTDOWN_SET;
  endproperty
  a_sd_byte: assert property (p_sd_byte)
    else $error("Shutdown byte not set.");
endmodule : diag_monitor
`default_nettype wire

// ==== verif/diag_host_model.sv ====
// Monitoring host model that reads and clears diagnostic bytes.
`timescale 1ns/1ps
`default_nettype none
module diag_host_model (
  input wire logic clk_sys,
  input wire logic diag_rd_valid,
  input wire logic [7:0] diag_rd_data,
  output var diag_pkg::diag_req_t diag_req
);
  initial diag_req = '0;

  // Issues one read and waits a bounded time for the answer.
  task automatic read_byte(input logic [5:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge clk_sys);
    diag_req <= {1'b1, 1'b0, a};
    @(posedge clk_sys);
    diag_req <= {1'b0, 1'b0, ~a};
    for (int n = 0; n < 4; n++)
    begin
      @(posedge clk_sys);
      if (diag_rd_valid === 1'b1)
      begin
        d = diag_rd_data;
        break;
      end
    end
  endtask : read_byte

  // Issues one clear; no answer is returned.
  task automatic clear_byte(input logic [5:0] a);
    @(posedge clk_sys);
    diag_req <= {1'b1, 1'b1, a};
    @(posedge clk_sys);
    diag_req <= {1'b0, 1'b0, ~a};
  endtask : clear_byte
endmodule : diag_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench of the diagnostic memory block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic host_if_sel = 1'b1;
  diag_pkg::diag_req_t diag_req;
  logic diag_rd_valid, diag_uses_spi, host_rd_valid, illum_en;
  logic mirror_park, mirror_power_en, host_irq, shutdown_flag;
  logic [7:0] diag_rd_data, host_rd_data, operating_mode;
  logic [4:0] shutdown_cause_q;
  logic host_rd_req = 1'b0, sw_alive = 1'b0, mode_req = 1'b0;
  logic mode_req_display = 1'b0, video_frame_done = 1'b0;
  logic shutdown_req = 1'b0, illum_req = 1'b0, mirror_parked = 1'b0;
  logic [5:0] host_rd_addr = 6'h00;
  logic [7:0] comp_state = 8'h08, reset_cause = 8'h07;
  diag_pkg::err_event_t err_event = '0;
  logic [31:0] video_checksum = 32'h0;
  logic [4:0] shutdown_cause = 5'h00;
  int num_errors = 0;
  int n_compared = 0;

  always #10 clk_sys = ~clk_sys;

  diag_monitor #(.ACTIVITY_TICK(8)) i_diag_monitor (
    .clk_sys(clk_sys), .reset(reset), .host_if_sel(host_if_sel),
    .diag_req(diag_req), .diag_rd_valid(diag_rd_valid),
    .diag_rd_data(diag_rd_data), .diag_uses_spi(diag_uses_spi),
    .host_rd_req(host_rd_req), .host_rd_addr(host_rd_addr),
    .host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data),
    .sw_alive(sw_alive), .mode_req(mode_req),
    .mode_req_display(mode_req_display), .comp_state(comp_state),
    .reset_cause(reset_cause), .err_event(err_event),
    .video_frame_done(video_frame_done),
    .video_checksum(video_checksum), .shutdown_req(shutdown_req),
    .shutdown_cause(shutdown_cause), .illum_req(illum_req),
    .mirror_parked(mirror_parked), .illum_en(illum_en),
    .mirror_park(mirror_park), .mirror_power_en(mirror_power_en),
    .host_irq(host_irq), .shutdown_flag(shutdown_flag),
    .shutdown_cause_q(shutdown_cause_q), .operating_mode(operating_mode)
  );

  diag_host_model i_diag_host_model (
    .clk_sys(clk_sys), .diag_rd_valid(diag_rd_valid),
    .diag_rd_data(diag_rd_data), .diag_req(diag_req)
  );

  task automatic results();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_diag_host_model.read_byte(a, d);
    chk_byte(d, e);
  endtask : rd_chk

  task automatic t_init();
    cyc(2);
    chk_bit(diag_uses_spi, 1'b0);
    rd_chk(6'h00, 8'h01);
    rd_chk(6'h03, 8'h08);
    rd_chk(6'h04, 8'h07);
    rd_chk(6'h0F, 8'h00);
    for (int i = 5; i < 64; i++)
      if (i < 11 || (i > 15 && i < 20) || i > 23)
        rd_chk(6'(i), 8'h00);
    comp_state <= 8'h0D;
    cyc(2);
    rd_chk(6'h03, 8'h0D);
  endtask : t_init

  task automatic set_mode(input logic disp, input logic [7:0] e);
    @(posedge clk_sys);
    mode_req <= 1'b1;
    mode_req_display <= disp;
    @(posedge clk_sys);
    mode_req <= 1'b0;
    @(posedge clk_sys);
    chk_byte(operating_mode, e);
    rd_chk(6'h00, e);
  endtask : set_mode

  task automatic t_mode();
    set_mode(1'b1, 8'h02);
    set_mode(1'b0, 8'h01);
    i_diag_host_model.clear_byte(6'h00);
    rd_chk(6'h00, 8'h00);
    set_mode(1'b1, 8'h02);
  endtask : t_mode

  task automatic t_errors();
    @(posedge clk_sys);
    err_event <= {1'b1, 12'h5A3, 1'b1};
    @(posedge clk_sys);
    err_event <= {1'b1, 12'hABC, 1'b0};
    @(posedge clk_sys);
    err_event <= '0;
    rd_chk(6'h0B, 8'h02);
    rd_chk(6'h0C, 8'hBC);
    rd_chk(6'h0D, 8'h0A);
    rd_chk(6'h0E, 8'h01);
    i_diag_host_model.clear_byte(6'h0B);
    i_diag_host_model.clear_byte(6'h0E);
    rd_chk(6'h0B, 8'h00);
    rd_chk(6'h0E, 8'h00);
    @(posedge clk_sys);
    err_event <= {1'b1, 12'h123, 1'b1};
    @(posedge clk_sys);
    err_event <= '0;
    rd_chk(6'h0B, 8'h03);
    rd_chk(6'h0E, 8'h02);
    rd_chk(6'h0D, 8'h01);
  endtask : t_errors

  task automatic t_activity();
    cyc(40);
    rd_chk(6'h01, 8'h00);
    @(posedge clk_sys);
    sw_alive <= 1'b1;
    @(posedge clk_sys);
    sw_alive <= 1'b0;
    cyc(20);
    rd_chk(6'h01, 8'h01);
    rd_chk(6'h02, 8'h00);
  endtask : t_activity

  task automatic t_frame();
    logic [31:0] c;
    c = 32'hA1B2C3D4;
    @(posedge clk_sys);
    video_checksum <= c;
    video_frame_done <= 1'b1;
    @(posedge clk_sys);
    video_frame_done <= 1'b0;
    video_checksum <= ~c;
    for (int i = 0; i < 4; i++)
      rd_chk(6'(20 + i), c[8*i+:8]);
  endtask : t_frame

  task automatic t_host_port();
    fork
      rd_chk(6'h00, 8'h02);
      begin
        @(posedge clk_sys);
        host_rd_req <= 1'b1;
        host_rd_addr <= 6'h03;
        @(posedge clk_sys);
        host_rd_req <= 1'b0;
        host_rd_addr <= 6'h3C;
        @(posedge clk_sys);
        chk_bit(host_rd_valid, 1'b1);
        chk_byte(host_rd_data, 8'h0D);
      end
    join
    rd_chk(6'h03, 8'h0D);
  endtask : t_host_port

  task automatic fire(input logic [4:0] c);
    @(posedge clk_sys);
    shutdown_req <= 1'b1;
    shutdown_cause <= c;
    @(posedge clk_sys);
    shutdown_req <= 1'b0;
    @(posedge clk_sys);
  endtask : fire

  task automatic t_shutdown();
    logic [4:0] bad [3];
    bad = '{5'h00, 5'h0F, 5'h18};
    illum_req <= 1'b1;
    foreach (bad[i])
    begin
      fire(bad[i]);
      chk_bit(shutdown_flag, 1'b0);
      chk_bit(host_irq, 1'b0);
    end
    chk_bit(illum_en, 1'b1);
    fire(5'h17);
    chk_bit(illum_en, 1'b0);
    chk_bit(mirror_park, 1'b1);
    chk_bit(mirror_power_en, 1'b1);
    chk_bit(host_irq, 1'b1);
    chk_bit(shutdown_flag, 1'b1);
    chk_byte(operating_mode, 8'h01);
    chk_byte({3'b000, shutdown_cause_q}, 8'h17);
    mirror_parked <= 1'b1;
    cyc(3);
    chk_bit(mirror_power_en, 1'b0);
    set_mode(1'b1, 8'h01);
    rd_chk(6'h0F, 8'h01);
    rd_chk(6'h0B, 8'h03);
    reset <= 1'b1;
    cyc(5);
    reset <= 1'b0;
    host_if_sel <= 1'b0;
    illum_req <= 1'b0;
    mirror_parked <= 1'b0;
    cyc(2);
    chk_bit(host_irq, 1'b0);
    chk_bit(mirror_power_en, 1'b1);
    chk_bit(diag_uses_spi, 1'b1);
    rd_chk(6'h00, 8'h01);
    rd_chk(6'h0F, 8'h00);
  endtask : t_shutdown

  initial
  begin
    cyc(5);
    reset <= 1'b0;
    t_init();
    t_mode();
    t_errors();
    t_activity();
    t_frame();
    t_host_port();
    t_shutdown();
    results();
  end

  initial
  begin
    #200000;
    num_errors++;
    results();
  end
endmodule : tb_top
`default_nettype wire
